// File: hdl/acsp_amp_control_serial_port.v
// Purpose: Mode select, two-wire slave registers and limiter timing
// Assumes: aclk 100 MHz; serial clock up to 400 kHz, sampled as plain data
// Notes:   Analog limiter and boost stage sit outside; this block drives their controls
`include "acsp_defines.vh"
`default_nettype none

module acsp_amp_control_serial_port (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Device pins
  input  wire        interface_select_strap,
  input  wire        shutdown_n_pin,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  // Analog controls
  output reg         amplifier_enable,
  output reg         boost_enable,
  output reg         second_input,
  output reg  [4:0]  gain_db,
  output reg         automatic_level_limiter,
  output reg  [2:0]  limit_level,
  output reg         fast_turn_on,
  output reg  [7:0]  attack_coefficient,
  output reg  [7:0]  release_coefficient,
  output reg  [31:0] attack_interval,
  output reg  [31:0] release_interval,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_ADDR  = 4'h1;
  localparam [3:0] ST_AACK  = 4'h2;
  localparam [3:0] ST_INDEX = 4'h3;
  localparam [3:0] ST_IACK  = 4'h4;
  localparam [3:0] ST_DATA  = 4'h5;
  localparam [3:0] ST_DACK  = 4'h6;
  localparam [3:0] ST_READ  = 4'h7;
  localparam [3:0] ST_MACK  = 4'h8;
  localparam [3:0] ST_SKIP  = 4'h9;

  // ----------------------------------------------------------------
  // Coefficient decode
  // ----------------------------------------------------------------
  function [7:0] atk_coef;
    input [1:0] code;
    begin
      case (code)
        2'h0:    atk_coef = `ACSP_ATK_COEF_00;
        2'h1:    atk_coef = `ACSP_ATK_COEF_01;
        2'h2:    atk_coef = `ACSP_ATK_COEF_10;
        default: atk_coef = `ACSP_ATK_COEF_11;
      endcase
    end
  endfunction

  function [7:0] rls_coef;
    input [1:0] code;
    begin
      case (code)
        2'h0:    rls_coef = `ACSP_RLS_COEF_00;
        2'h1:    rls_coef = `ACSP_RLS_COEF_01;
        2'h2:    rls_coef = `ACSP_RLS_COEF_10;
        default: rls_coef = `ACSP_RLS_COEF_11;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [3:0] sync_a;
  reg  [3:0] sync_b;
  reg        scl_d;
  reg        sda_d;
  wire       strap_s = sync_b[0];
  wire       sdn_s   = sync_b[1];
  wire       scl_s   = sync_b[2];
  wire       sda_s   = sync_b[3];

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 4'hF;
      sync_b <= 4'hF;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      sync_a <= {sda_in, scl_in, shutdown_n_pin, interface_select_strap};
      sync_b <= sync_a;
      scl_d  <= scl_s;
      sda_d  <= sda_s;
    end
  end

  // Clock only sampled, never driven: slave only
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire serial   = strap_s;

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  reg  [3:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg  [7:0] index;
  reg  [7:0] tx;
  reg        rd_mode;
  reg  [3:0] reg_sd;
  reg  [6:0] reg_lim;
  reg  [1:0] reg_gain;
  reg        serial_lock;
  reg  [7:0] rd_byte;

  assign sda_out = 1'b0;

  always @* begin
    case (index)
      `ACSP_IDX_SHUTDOWN: rd_byte = {4'h0, reg_sd};
      `ACSP_IDX_LIMITER:  rd_byte = {1'b0, reg_lim};
      `ACSP_IDX_GAIN:     rd_byte = {6'h00, reg_gain};
      default:            rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      index    <= 8'h00;
      tx       <= 8'h00;
      rd_mode  <= 1'b0;
      sda_oe   <= 1'b0;
      reg_sd   <= `ACSP_RST_SHUTDOWN;
      reg_lim  <= `ACSP_RST_LIMITER;
      reg_gain <= `ACSP_RST_GAIN;
    end else if (!serial) begin
      // Shared pins are mode inputs; an open transfer is dropped
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      state   <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop_c) begin
      // Partial bytes are discarded here
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_INDEX, ST_DATA: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            // Eight bits taken; the ninth clock is the acknowledge
            if (state == ST_ADDR) begin
              if (shift[7:1] == `ACSP_OWN_ADDR) begin
                sda_oe  <= 1'b1;
                rd_mode <= shift[0];
                state   <= ST_AACK;
              end else begin
                state <= ST_SKIP;
              end
            end else if (state == ST_INDEX) begin
              index  <= shift;
              sda_oe <= 1'b1;
              state  <= ST_IACK;
            end else begin
              sda_oe <= 1'b1;
              state  <= ST_DACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rd_mode) begin
              tx      <= {rd_byte[6:0], 1'b0};
              sda_oe  <= ~rd_byte[7];
              bit_cnt <= 4'h0;
              state   <= ST_READ;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_INDEX;
            end
          end
        end
        ST_IACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state  <= ST_DATA;
          end
        end
        ST_DACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state  <= ST_DATA;
            if (!serial_lock) begin
              // Commit only once the acknowledge clock has ended
              case (index)
                `ACSP_IDX_SHUTDOWN: reg_sd   <= shift[3:0];
                `ACSP_IDX_LIMITER:  reg_lim  <= shift[6:0];
                `ACSP_IDX_GAIN:     reg_gain <= shift[1:0];
                default:            reg_gain <= reg_gain;
              endcase
            end
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state  <= ST_MACK;
            end else begin
              sda_oe <= ~tx[7];
              tx     <= {tx[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          // Master acknowledge repeats the byte, no acknowledge ends it
          if (scl_rise) begin
            state <= sda_s ? ST_SKIP : ST_AACK;
          end
        end
        ST_SKIP: begin
          sda_oe <= 1'b0;
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode and analog controls
  // ----------------------------------------------------------------
  reg  [4:0] next_gain;
  reg        next_boost;
  reg        next_second;
  reg        next_amp;
  wire [1:0] atk_code = reg_lim[`ACSP_LIM_ATK_HI:`ACSP_LIM_ATK_LO];
  wire [1:0] rls_code = reg_lim[`ACSP_LIM_RLS_HI:`ACSP_LIM_RLS_LO];
  wire [2:0] lvl      = reg_lim[`ACSP_LIM_LEVEL_HI:0];

  always @* begin
    if (serial) begin
      next_amp    = reg_sd[`ACSP_SD_ENABLE];
      next_boost  = reg_sd[`ACSP_SD_BOOST];
      next_second = reg_sd[`ACSP_SD_INSEL];
      if (next_boost)
        next_gain = `ACSP_GAIN_BST_BASE + (reg_gain[1] ? 5'h06 : 5'h00)
                    + (reg_gain[0] ? `ACSP_GAIN_BST_STEP : 5'h00);
      else
        next_gain = (reg_gain[1] ? 5'h0C : 5'h00) + (reg_gain[0] ? `ACSP_GAIN_STEP : 5'h00);
    end else begin
      next_amp    = 1'b1;
      next_boost  = sda_s;
      next_second = sda_s;
      if (sda_s)
        next_gain = scl_s ? `ACSP_GAIN_HW_IN2_HI : `ACSP_GAIN_HW_IN2_LO;
      else
        next_gain = scl_s ? `ACSP_GAIN_HW_IN1_HI : `ACSP_GAIN_HW_IN1_LO;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      amplifier_enable        <= 1'b0;
      boost_enable            <= 1'b0;
      second_input            <= 1'b0;
      gain_db                 <= 5'h00;
      automatic_level_limiter <= 1'b0;
      limit_level             <= 3'h0;
      fast_turn_on            <= 1'b0;
      attack_coefficient      <= `ACSP_ATK_COEF_00;
      release_coefficient     <= `ACSP_RLS_COEF_00;
      attack_interval         <= 32'h0000_0000;
      release_interval        <= 32'h0000_0000;
    end else begin
      amplifier_enable <= next_amp & sdn_s;
      // Boost stage holds nominal rail and tracks large output itself
      boost_enable     <= next_boost & next_amp & sdn_s;
      second_input     <= next_second;
      gain_db          <= next_gain;
      // Limiter with its fixed attenuation span and 6 dB timing points
      automatic_level_limiter <= serial & next_boost & next_amp & sdn_s;
      limit_level      <= serial ? lvl : 3'h0;
      fast_turn_on     <= serial & reg_sd[`ACSP_SD_TURNON];
      attack_coefficient  <= atk_coef(atk_code);
      release_coefficient <= rls_coef(rls_code);
      // Nanoseconds, coefficient held times ten
      attack_interval <= (32'd10000 * `ACSP_ATK_RES_KOHM * `ACSP_CSET_NF)
                         / {24'h000000, atk_coef(atk_code)};
      // Microseconds, coefficient held times ten
      release_interval <= (32'd10000 * `ACSP_RLS_RES_MOHM * `ACSP_CSET_NF)
                          / {24'h000000, rls_coef(rls_code)};
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg        aw_held;
  reg        w_held;
  reg  [3:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACSP_RESP_OKAY;
      serial_lock  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `ACSP_AXI_CONTROL) begin
          s_axi_bresp <= `ACSP_RESP_OKAY;
          if (w_strb[0])
            serial_lock <= w_data[0];
        end else begin
          s_axi_bresp <= `ACSP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ACSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `ACSP_RESP_OKAY;
      case (s_axi_araddr)
        `ACSP_AXI_STATUS:
          s_axi_rdata <= {10'h000, limit_level, gain_db, state, 3'h0, fast_turn_on,
                          automatic_level_limiter, second_input, boost_enable,
                          amplifier_enable, sdn_s, serial};
        `ACSP_AXI_ATTACK:  s_axi_rdata <= attack_interval;
        `ACSP_AXI_RELEASE: s_axi_rdata <= release_interval;
        `ACSP_AXI_CONTROL: s_axi_rdata <= {31'h0000_0000, serial_lock};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `ACSP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // acsp_amp_control_serial_port

`default_nettype wire

// File: hdl/acsp_defines.vh
// Purpose: Constants of the amplifier control serial port
// Assumes: Included by hdl/acsp_amp_control_serial_port.v
// Notes:   Definitions only
`ifndef ACSP_DEFINES_VH
`define ACSP_DEFINES_VH

// ----------------------------------------------------------------
// Two-wire slave
// ----------------------------------------------------------------
`define ACSP_OWN_ADDR       7'h2A
`define ACSP_IDX_SHUTDOWN   8'h00
`define ACSP_IDX_LIMITER    8'h01
`define ACSP_IDX_GAIN       8'h02
`define ACSP_IDX_TEST       8'h03
`define ACSP_RST_SHUTDOWN   4'h0
`define ACSP_RST_LIMITER    7'h00
`define ACSP_RST_GAIN       2'h0

// Field positions
`define ACSP_SD_ENABLE      0
`define ACSP_SD_BOOST       1
`define ACSP_SD_INSEL       2
`define ACSP_SD_TURNON      3
`define ACSP_LIM_LEVEL_HI   2
`define ACSP_LIM_ATK_HI     4
`define ACSP_LIM_ATK_LO     3
`define ACSP_LIM_RLS_HI     6
`define ACSP_LIM_RLS_LO     5

// ----------------------------------------------------------------
// Limiter timing (coefficients times ten)
// ----------------------------------------------------------------
`define ACSP_ATK_COEF_00    8'h18
`define ACSP_ATK_COEF_01    8'h11
`define ACSP_ATK_COEF_10    8'h0D
`define ACSP_ATK_COEF_11    8'h09
`define ACSP_RLS_COEF_00    8'h28
`define ACSP_RLS_COEF_01    8'h35
`define ACSP_RLS_COEF_10    8'h5F
`define ACSP_RLS_COEF_11    8'h76
`define ACSP_ATK_RES_KOHM   20
`define ACSP_RLS_RES_MOHM   20
`define ACSP_CSET_NF        100
`define ACSP_LIMIT_SPAN_DB  8
`define ACSP_BOOST_NOM_V    6

// ----------------------------------------------------------------
// Gains in dB
// ----------------------------------------------------------------
`define ACSP_GAIN_HW_IN1_LO 5'h00
`define ACSP_GAIN_HW_IN1_HI 5'h06
`define ACSP_GAIN_HW_IN2_LO 5'h18
`define ACSP_GAIN_HW_IN2_HI 5'h1E
`define ACSP_GAIN_STEP      5'h06
`define ACSP_GAIN_BST_BASE  5'h15
`define ACSP_GAIN_BST_STEP  5'h03

// ----------------------------------------------------------------
// AXI4-Lite map (byte addresses)
// ----------------------------------------------------------------
`define ACSP_AXI_STATUS     4'h0
`define ACSP_AXI_ATTACK     4'h4
`define ACSP_AXI_RELEASE    4'h8
`define ACSP_AXI_CONTROL    4'hC
`define ACSP_RESP_OKAY      2'h0
`define ACSP_RESP_SLVERR    2'h2

`endif

// File: bench/acsp_bus_master.sv
// Purpose: Two-wire bus master and pin driver
// Assumes: One bit takes 16 aclk, a 160 ns serial clock
// Notes:   Open-drain data; the bench pulls up
`default_nettype none
module acsp_bus_master (
  // Clock
  input  wire logic aclk,
  // Bus lines
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Pin mode: lines are gain and select levels
  task automatic set_pins(input logic gain, input logic sel);
    scl <= gain;
    sda_low <= !sel;
    tick(8);
  endtask
  // Data moves only while the clock is low
  task automatic clock_bit(input logic b, output logic seen);
    sda_low <= !b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    seen = sda_line;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic start;
    sda_low <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b0;
    tick(8);
  endtask
  // Fewer than eight bits cuts the byte short
  task automatic send_byte(input logic [7:0] d, input int nbits, output logic ack);
    logic seen;
    ack = 1'b0;
    for (int i = 7; i >= 8 - nbits; i--)
      clock_bit(d[i], seen);
    if (nbits == 8) begin
      clock_bit(1'b1, seen);
      ack = !seen;
    end
  endtask
  task automatic i2c_write(input logic [6:0] dev, input logic [7:0] idx,
                           input logic [7:0] dat, input int nbits, output logic [2:0] acks);
    start();
    send_byte({dev, 1'b0}, 8, acks[2]);
    send_byte(idx, 8, acks[1]);
    send_byte(dat, nbits, acks[0]);
    stop();
  endtask
  task automatic i2c_read(input logic [6:0] dev, output logic [7:0] d, output logic ack);
    logic seen;
    start();
    send_byte({dev, 1'b1}, 8, ack);
    for (int i = 7; i >= 0; i--)
      clock_bit(1'b1, d[i]);
    clock_bit(1'b1, seen);
    stop();
  endtask
endmodule // acsp_bus_master
`default_nettype wire

// File: bench/acsp_checker.sv
// Purpose: Concurrent checks of the serial port
// Assumes: Bound to the top module; one clock domain
// Notes:   Counts cover the pin synchronisers
`default_nettype none
module acsp_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Pins
  input wire logic        interface_select_strap,
  input wire logic        shutdown_n_pin,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // Controls
  input wire logic        amplifier_enable,
  input wire logic        boost_enable,
  input wire logic        second_input,
  input wire logic [4:0]  gain_db,
  input wire logic        automatic_level_limiter,
  input wire logic [7:0]  attack_coefficient,
  input wire logic [7:0]  release_coefficient,
  input wire logic [31:0] attack_interval,
  input wire logic [31:0] release_interval,
  // Register bus read channel
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_pin_mode;
    (!interface_select_strap && shutdown_n_pin && $stable(scl_in) && $stable(sda_in)) [*6];
  endsequence
  sequence s_serial_on;
    (interface_select_strap && shutdown_n_pin) [*4] ##0 amplifier_enable;
  endsequence
  property p_alc_boost;
    automatic_level_limiter |-> boost_enable && amplifier_enable;
  endproperty
  a_alc_boost: assert property (p_alc_boost) else $error("limiter on without boost");
  property p_alc_pin;
    s_pin_mode |-> !automatic_level_limiter;
  endproperty
  a_alc_pin: assert property (p_alc_pin) else $error("limiter on in pin mode");
  property p_pin_gain;
    s_pin_mode |-> gain_db == (sda_in ? (scl_in ? 5'h1E : 5'h18) : (scl_in ? 5'h06 : 5'h00))
      && second_input == sda_in && boost_enable == sda_in && amplifier_enable;
  endproperty
  a_pin_gain: assert property (p_pin_gain) else $error("pin mode setting wrong");
  property p_shutdown;
    !shutdown_n_pin [*4] |-> !amplifier_enable && !boost_enable && !automatic_level_limiter;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("active while shut down");
  property p_serial_gain;
    s_serial_on |-> (boost_enable ? gain_db inside {5'h15, 5'h18, 5'h1B, 5'h1E}
                                  : gain_db inside {5'h00, 5'h06, 5'h0C, 5'h12});
  endproperty
  a_serial_gain: assert property (p_serial_gain) else $error("serial gain out of set");
  property p_no_slave;
    s_pin_mode |-> !sda_oe;
  endproperty
  a_no_slave: assert property (p_no_slave) else $error("data pulled in pin mode");
  property p_oe_low_phase;
    $changed(sda_oe) |-> !scl_in && !sda_out;
  endproperty
  a_oe_low_phase: assert property (p_oe_low_phase) else $error("data moved, clock high");
  property p_oe_stands;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("pulled bit too short");
  property p_coef_set;
    attack_coefficient inside {8'h18, 8'h11, 8'h0D, 8'h09}
      && release_coefficient inside {8'h28, 8'h35, 8'h5F, 8'h76};
  endproperty
  a_coef_set: assert property (p_coef_set) else $error("coefficient off table");
  property p_atk_time;
    $stable(attack_coefficient) [*3] |-> attack_interval == 32'h01312D00 / attack_coefficient;
  endproperty
  a_atk_time: assert property (p_atk_time) else $error("attack interval wrong");
  property p_rls_time;
    $stable(release_coefficient) [*3] |-> release_interval == 32'h01312D00 / release_coefficient;
  endproperty
  a_rls_time: assert property (p_rls_time) else $error("release interval wrong");
  property p_read_holds;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("read data dropped early");
endmodule // acsp_checker
bind acsp_amp_control_serial_port acsp_checker u_checker (
  .aclk, .aresetn, .interface_select_strap, .shutdown_n_pin, .scl_in, .sda_in, .sda_out,
  .sda_oe, .amplifier_enable, .boost_enable, .second_input, .gain_db,
  .automatic_level_limiter, .attack_coefficient, .release_coefficient, .attack_interval,
  .release_interval, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// File: bench/test_acsp_amp_control_serial_port.sv
// Purpose: Self-checking bench of the serial port
// Assumes: Link model drives the shared pins
// Notes:   Gain checked at every code
`include "acsp_defines.vh"
`default_nettype none
module test_acsp_amp_control_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, interface_select_strap, shutdown_n_pin, scl, sda_low;
  logic        sda_out, sda_oe, amplifier_enable, boost_enable, second_input;
  logic        automatic_level_limiter, fast_turn_on;
  logic [2:0]  limit_level;
  logic [4:0]  gain_db;
  logic [7:0]  attack_coefficient, release_coefficient;
  logic [31:0] attack_interval, release_interval, s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire logic   sda_line;
  int          fails, total_checks;
  logic [4:0]  hw_gain [4] = '{5'h00, 5'h06, 5'h18, 5'h1E};
  logic [7:0]  atk_tab [4] = '{8'h18, 8'h11, 8'h0D, 8'h09};
  logic [7:0]  rls_tab [4] = '{8'h28, 8'h35, 8'h5F, 8'h76};
  // Open-drain data with pull-up
  assign sda_line = !((sda_oe && !sda_out) || sda_low);
  acsp_amp_control_serial_port dut (
    .aclk, .aresetn, .interface_select_strap, .shutdown_n_pin, .scl_in(scl),
    .sda_in(sda_line), .sda_out, .sda_oe, .amplifier_enable, .boost_enable, .second_input,
    .gain_db, .automatic_level_limiter, .limit_level, .fast_turn_on, .attack_coefficient,
    .release_coefficient, .attack_interval, .release_interval, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  acsp_bus_master master (.aclk, .sda_line, .scl, .sda_low);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One write or one read; bready or rready stays up until the answer
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    logic        got;
    @(posedge aclk);
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (int n = 0; n < 100 && !got; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) begin
        got = 1'b1;
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
      end
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!got) begin
      fails++;
      stop_test();
    end else begin
      check("bus resp", r, er);
      if (!wr)
        check("read data", q, d);
    end
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] dat);
    logic [2:0] acks;
    master.i2c_write(`ACSP_OWN_ADDR, idx, dat, 8, acks);
    check("acks", acks, 3'b111);
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin : main
    logic [7:0] d;
    logic [2:0] acks;
    logic       ack;
    fails = 0;
    total_checks = 0;
    aresetn = 1'b0;
    interface_select_strap = 1'b0;
    shutdown_n_pin = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    check("reset coef", {attack_coefficient, release_coefficient}, 16'h1828);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      master.set_pins(i[0], i[1]);
      check("pin gain", gain_db, hw_gain[i]);
      check("pin input", {second_input, boost_enable, automatic_level_limiter,
                          amplifier_enable}, {i[1], i[1], 2'b01});
    end
    shutdown_n_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    check("shutdown", {amplifier_enable, boost_enable}, 2'b00);
    shutdown_n_pin <= 1'b1;
    master.set_pins(1'b1, 1'b1);
    interface_select_strap <= 1'b1;
    repeat (6) @(posedge aclk);
    check("serial idle", amplifier_enable, 1'b0);
    reg_wr(8'h01, 8'h01);
    for (int b = 0; b < 2; b++) begin
      reg_wr(8'h00, {6'h00, b[0], 1'b1});
      check("limiter", automatic_level_limiter, b[0]);
      for (int g = 0; g < 4; g++) begin
        reg_wr(8'h02, g[7:0]);
        check("gain", gain_db, b ? 5'h15 + 5'h03 * g[4:0] : 5'h06 * g[4:0]);
      end
    end
    for (int c = 0; c < 4; c++) begin
      reg_wr(8'h01, {1'b0, c[1:0], c[1:0], 3'b001});
      check("attack coef", attack_coefficient, atk_tab[c]);
      check("release coef", release_coefficient, rls_tab[c]);
      axi(1'b0, 4'h4, 32'h01312D00 / atk_tab[c], 2'h0);
      axi(1'b0, 4'h8, 32'h01312D00 / rls_tab[c], 2'h0);
    end
    master.i2c_read(`ACSP_OWN_ADDR, d, ack);
    check("link read", {ack, d}, 9'h179);
    master.i2c_write(`ACSP_OWN_ADDR ^ 7'h01, 8'h02, 8'h00, 8, acks);
    check("foreign", {acks, gain_db}, {3'b000, 5'h1E});
    master.i2c_write(`ACSP_OWN_ADDR, 8'h02, 8'h00, 5, acks);
    check("cut short", {acks, gain_db}, {3'b110, 5'h1E});
    axi(1'b1, 4'hC, 32'h1, 2'h0);
    master.i2c_write(`ACSP_OWN_ADDR, 8'h02, 8'h00, 8, acks);
    check("locked", gain_db, 5'h1E);
    axi(1'b1, 4'hC, 32'h0, 2'h0);
    axi(1'b1, 4'h4, 32'h0, 2'h2);
    interface_select_strap <= 1'b0;
    master.set_pins(1'b0, 1'b1);
    check("pin limiter", automatic_level_limiter, 1'b0);
    stop_test();
  end
endmodule // test_acsp_amp_control_serial_port
`default_nettype wire
